// >>> biu_bus_partner.sv
// Far side: memory, I/O and interrupt controller on the local bus.
// Reads answer a fixed pattern of the latched address.
`timescale 1ns/100ps
`include "biu_defs.svh"
module biu_bus_partner (
	input wire logic clk,
	input wire logic slow,
	input wire logic [7:0] vec_type,
	input wire logic [7:0] muxed_addr_data_out,
	input wire logic [7:0] upper_addr_lines,
	input wire biu_pkg::min_ctl_t min_ctl,
	input wire biu_pkg::max_ctl_t max_ctl,
	output logic [7:0] muxed_addr_data_in,
	output logic ready = 1'b1
);
	logic [15:0] addr = 16'h0;
	logic [3:0] cyc = 4'h0;
	logic [1:0] hold = 2'h0;
	logic ackf = 1'b0;
	wire logic ack;
	wire logic [7:0] resp;
	assign ack = min_ctl.irq_ack_strobe || max_ctl[3:1] == `ST_IRQ_ACK;
	assign resp = (ack || ackf) ? vec_type : addr[7:0] ^ addr[15:8] ^ 8'h5a;
	always @(posedge clk) begin
		cyc <= cyc + 4'h1;
		ready <= !slow || cyc[1];
		// Local controller answers itself; transceiver stays off
		ackf <= ack || (ackf && !min_ctl.rd_strobe && !min_ctl.addr_latch);
		if (min_ctl.addr_latch)
			addr <= {upper_addr_lines, muxed_addr_data_out};
		hold <= (ack || min_ctl.rd_strobe) ? 2'h3 : hold - {1'b0, hold != 2'h0};
	end
	// Write strobe kind and transceiver controls unused here
	// Released bus shows a moving pattern
	assign muxed_addr_data_in = (ack || min_ctl.rd_strobe || hold != 2'h0) ?
		resp : ~resp ^ {4'h0, cyc};
endmodule // biu_bus_partner

// >>> biu_defs.svh
// Constants for the byte-wide bus interface unit.
// Included by the package and the unit; definitions only.
`ifndef BIU_DEFS_SVH
`define BIU_DEFS_SVH
`define QUEUE_DEPTH 3'h4
`define WORD_EXTRA_CYCLES 3'h4
`define ST_IRQ_ACK 3'h0
`define ST_IO_READ 3'h1
`define ST_IO_WRITE 3'h2
`define ST_HALT 3'h3
`define ST_CODE_READ 3'h4
`define ST_DATA_READ 3'h5
`define ST_DATA_WRITE 3'h6
`define ST_PASSIVE 3'h7
`define VECTOR_SHIFT 2
`endif

// >>> biu_pkg.sv
// Types for the byte-wide bus interface unit.
// Assumes biu_defs.svh is on the include path.
`include "biu_defs.svh"
package biu_pkg;
	typedef enum logic [2:0] {
		REQ_NONE, REQ_MEM_RD, REQ_MEM_WR, REQ_IO_RD, REQ_IO_WR, REQ_HALT
	} req_kind_t;
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] wdata;
		logic word;
		req_kind_t kind;
	} exec_req_t;
	typedef struct packed {
		logic addr_latch;
		logic io_select;
		logic xcvr_direction;
		logic xcvr_output_enable;
		logic min_cfg_status_copy;
		logic rd_strobe;
		logic wr_strobe;
		logic irq_ack_strobe;
	} min_ctl_t;
	typedef struct packed {
		logic cycle_status_hi;
		logic cycle_status_mid;
		logic cycle_status_lo;
		logic bus_lock;
	} max_ctl_t;
endpackage

// >>> biu_props.sv
// Checker for the byte-wide bus interface unit.
// Bound to the unit below; sees only its ports.
`timescale 1ns/100ps
`include "biu_defs.svh"
module biu_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic config_strap,
	input wire logic exec_valid,
	input wire biu_pkg::exec_req_t exec_req,
	input wire logic exec_done,
	input wire logic [9:0] vector_ptr,
	input wire logic vector_valid,
	input wire logic muxed_addr_data_oe,
	input wire logic [7:0] upper_addr_lines,
	input wire biu_pkg::min_ctl_t min_ctl,
	input wire biu_pkg::max_ctl_t max_ctl
);
	wire logic [2:0] code;
	assign code = max_ctl[3:1];
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_MAX_QUIET: assert property (
		(!config_strap)[*4] |-> min_ctl == '0) else $error("strobes in max");
	AST_MIN_PASSIVE: assert property (
		config_strap[*4] |-> code == `ST_PASSIVE) else $error("not passive");
	AST_UPPER_HELD: assert property (
		min_ctl.rd_strobe && $past(min_ctl.rd_strobe)
		|-> $stable(upper_addr_lines)) else $error("upper address moved");
	AST_READ_FLOAT: assert property (
		min_ctl.rd_strobe |-> !muxed_addr_data_oe) else $error("read driven");
	AST_ACK_FLOAT: assert property (
		min_ctl.irq_ack_strobe |-> !muxed_addr_data_oe) else $error("ack driven");
	AST_WORD_LONG: assert property (
		$rose(exec_valid) && exec_req.word |-> !exec_done[*8])
		else $error("word too short");
	AST_VEC_X4: assert property (
		vector_valid |-> vector_ptr[1:0] == 2'h0) else $error("vector not x4");
	AST_LOCK_ACK: assert property (
		max_ctl.bus_lock |-> code inside {`ST_IRQ_ACK, `ST_PASSIVE})
		else $error("lock outside ack");
	AST_WRITE_DRIVE: assert property (
		code == `ST_DATA_WRITE && $past(code) == `ST_DATA_WRITE
		|-> muxed_addr_data_oe) else $error("write data not driven");
	C_ACK: cover property (vector_valid);
	C_WORD: cover property (exec_done && exec_req.word);
	C_LOCK: cover property (max_ctl.bus_lock);
endmodule // biu_props
bind bus_interface_unit biu_props u_biu_props (.clk(clk), .sys_rst(sys_rst),
	.config_strap(config_strap), .exec_valid(exec_valid),
	.exec_req(exec_req), .exec_done(exec_done), .vector_ptr(vector_ptr),
	.vector_valid(vector_valid), .muxed_addr_data_oe(muxed_addr_data_oe),
	.upper_addr_lines(upper_addr_lines), .min_ctl(min_ctl),
	.max_ctl(max_ctl));

// >>> bus_interface_unit.sv
// Byte-wide bus interface unit: prefetch queue, byte cycles, status.
// Assumes execution-side requests on clk and external pins synchronised.
// Function
// - Low mode strap selects maximum mode; latch/transceiver controls left external.
// - Maximum mode drives three status lines coding each cycle type.
// - Each 16-bit operand moves as two consecutive byte cycles; an interrupt taken at the first byte's T4 replaces the second byte.
// - Prefetched code bytes sit in a four-byte queue.
// - Fetch a code byte whenever one queue byte is free.
// - Word access costs four clocks more than a single byte access.
// - Upper address lines are outputs held for the whole cycle.
// - No upper byte select output exists.
// - Minimum mode outputs status bit zero copy for full status.
// - Memory/IO select is high for IO, low for memory.
// - Minimum mode delays the halt address strobe by one clock.
// - Maskable interrupt runs two acknowledge cycles; type byte times four.
// - Maximum mode lock from T2 of first to T2 of second acknowledge, and again from the clock after T3 of the second through its T4.
// - Cycle starts with strobe and address in T1, removed in T2.
`timescale 1ns/100ps
`include "biu_defs.svh"
module bus_interface_unit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic config_strap,
	input wire logic ready,
	input wire logic irq_req,
	input wire logic flush,
	input wire logic [19:0] fetch_addr,
	input wire biu_pkg::exec_req_t exec_req,
	input wire logic exec_valid,
	output logic exec_done,
	output logic [15:0] exec_rdata,
	output logic [9:0] vector_ptr,
	output logic vector_valid,
	input wire logic queue_pop,
	output logic [7:0] queue_byte,
	output logic queue_valid,
	input wire logic [7:0] muxed_addr_data_in,
	output logic [7:0] muxed_addr_data_out,
	output logic muxed_addr_data_oe,
	output logic [3:0] addr_hi_status,
	output logic [7:0] upper_addr_lines,
	output biu_pkg::min_ctl_t min_ctl,
	output biu_pkg::max_ctl_t max_ctl
);
	typedef enum logic [2:0] {T_IDLE, T_1, T_2, T_3, T_W, T_4, T_HALT} tstate_t;
	tstate_t tst, next_tst;
	// Synchronised pins
	logic strap_s0, strap_s1, rdy_s0, rdy_s1, irq_s0, irq_s1;
	logic [7:0] din_s0, din_s1;
	// Prefetch queue
	logic [7:0] q_mem [0:3];
	logic [1:0] q_rd, q_wr;
	logic [2:0] q_cnt, q_pend;
	// Current cycle
	logic [2:0] cyc_code;
	logic [19:0] cyc_addr;
	logic [7:0] cyc_wbyte;
	logic cyc_second, cyc_is_fetch, cyc_is_exec, cyc_ack, ack_second;
	logic halt_delay, halted, exec_busy, ack_pending;
	// Capture stage, one clock after T4
	// Pin data passes two flops, so T4 sees the bus of T2; the clock
	// after T4 sees the bus of T3, while the strobe is still honoured.
	logic cap_fetch, cap_exec_last, cap_low, cap_vec, cap_read;
	logic [7:0] rlow;
	logic [19:0] next_addr;
	logic [2:0] next_code;

	always_ff @(posedge clk) begin
		strap_s0 <= config_strap;
		strap_s1 <= strap_s0;
		rdy_s0 <= ready;
		rdy_s1 <= rdy_s0;
		irq_s0 <= irq_req;
		irq_s1 <= irq_s0;
		din_s0 <= muxed_addr_data_in;
		din_s1 <= din_s0;
	end

	wire max_mode = ~strap_s1;
	wire q_room = (q_cnt + q_pend) < `QUEUE_DEPTH;
	wire take_irq = irq_s1 & ~cyc_ack & ~ack_pending;
	// Done pulse blocks a relaunch while the requester still holds valid
	wire exec_go = exec_valid & ~exec_busy & ~exec_done & ~halted;
	wire is_read = (cyc_code != `ST_IO_WRITE) && (cyc_code != `ST_DATA_WRITE);
	wire cyc_end = (tst == T_4);
	// Word operand needs another byte cycle
	wire more_bytes = cyc_is_exec & exec_req.word & ~cyc_second;
	wire start_irq = take_irq | (cyc_ack & cyc_end & ~ack_second);
	wire start_exec = exec_go | (more_bytes & cyc_end);
	wire start_fetch = q_room & ~flush;
	wire [2:0] exec_code =
		(exec_req.kind == biu_pkg::REQ_MEM_RD) ? `ST_DATA_READ :
		(exec_req.kind == biu_pkg::REQ_MEM_WR) ? `ST_DATA_WRITE :
		(exec_req.kind == biu_pkg::REQ_IO_RD) ? `ST_IO_READ :
		(exec_req.kind == biu_pkg::REQ_IO_WR) ? `ST_IO_WRITE :
		`ST_HALT;
	wire second_sel = more_bytes & cyc_end;
	wire [19:0] exec_addr = second_sel ? cyc_addr + 20'h1 : exec_req.addr;
	wire [7:0] exec_wbyte = second_sel ? exec_req.wdata[15:8] :
		exec_req.wdata[7:0];
	wire pick_irq = start_irq;
	wire pick_exec = ~pick_irq & start_exec;
	wire pick_fetch = ~pick_irq & ~pick_exec & start_fetch;
	wire can_start = (tst == T_IDLE) | cyc_end;
	wire launch = can_start & (pick_irq | pick_exec | pick_fetch);
	wire go_halt = launch & pick_exec & (exec_code == `ST_HALT);

	always_comb begin
		next_tst = tst;
		unique case (tst)
			T_IDLE, T_4: begin
				if (go_halt) begin
					next_tst = T_HALT;
				end else if (launch) begin
					next_tst = T_1;
				end else begin
					next_tst = T_IDLE;
				end
			end
			T_1: next_tst = T_2;
			T_2: next_tst = T_3;
			T_3, T_W: next_tst = rdy_s1 ? T_4 : T_W;
			T_HALT: next_tst = take_irq ? T_IDLE : T_HALT;
		endcase
	end

	always_comb begin
		next_code = `ST_CODE_READ;
		// Fetch address counts from the queue head
		next_addr = fetch_addr + {17'h0, 3'(q_cnt + q_pend)};
		if (pick_irq) begin
			next_code = `ST_IRQ_ACK;
			next_addr = 20'h0;
		end else if (pick_exec) begin
			next_code = exec_code;
			next_addr = exec_addr;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tst <= T_IDLE;
			cyc_code <= `ST_PASSIVE;
			cyc_addr <= 20'h0;
			cyc_wbyte <= 8'h0;
			cyc_second <= 1'b0;
			cyc_is_fetch <= 1'b0;
			cyc_is_exec <= 1'b0;
			cyc_ack <= 1'b0;
			ack_second <= 1'b0;
			ack_pending <= 1'b0;
			exec_busy <= 1'b0;
			halted <= 1'b0;
			halt_delay <= 1'b0;
			rlow <= 8'h0;
			cap_fetch <= 1'b0;
			cap_exec_last <= 1'b0;
			cap_low <= 1'b0;
			cap_vec <= 1'b0;
			cap_read <= 1'b0;
		end else begin
			cap_fetch <= cyc_end & cyc_is_fetch;
			cap_exec_last <= cyc_end & cyc_is_exec & ~more_bytes;
			cap_low <= cyc_end & cyc_is_exec & ~cyc_second;
			cap_vec <= cyc_end & ack_second;
			cap_read <= is_read;
			tst <= next_tst;
			halt_delay <= go_halt & ~max_mode;
			if (go_halt) begin
				halted <= 1'b1;
				cyc_code <= `ST_HALT;
			end else if (tst == T_HALT && take_irq) begin
				halted <= 1'b0;
			end
			if (launch & ~go_halt) begin
				cyc_code <= next_code;
				cyc_addr <= next_addr;
				cyc_wbyte <= exec_wbyte;
				cyc_second <= pick_exec & second_sel;
				cyc_is_fetch <= pick_fetch;
				cyc_is_exec <= pick_exec;
				cyc_ack <= pick_irq;
				ack_second <= pick_irq & cyc_ack;
				ack_pending <= pick_irq & ~cyc_ack;
			end else if (cyc_end) begin
				cyc_code <= `ST_PASSIVE;
				cyc_is_fetch <= 1'b0;
				cyc_is_exec <= 1'b0;
				cyc_ack <= 1'b0;
				ack_second <= 1'b0;
			end
			if (cyc_end & ack_second) begin
				ack_pending <= 1'b0;
			end
			if (launch & pick_exec & ~go_halt) begin
				exec_busy <= 1'b1;
			end else if (cap_exec_last) begin
				exec_busy <= 1'b0;
			end
			if (cap_low) begin
				rlow <= din_s1;
			end
		end
	end

	// Queue storage and pointers
	wire q_push = cap_fetch & ~flush;
	wire q_take = queue_pop & (q_cnt != 3'h0);
	always_ff @(posedge clk) begin
		if (sys_rst | flush) begin
			q_rd <= 2'h0;
			q_wr <= 2'h0;
			q_cnt <= 3'h0;
			q_pend <= 3'h0;
		end else begin
			if (q_push) begin
				q_mem[q_wr] <= din_s1;
				q_wr <= q_wr + 2'h1;
			end
			if (q_take) begin
				q_rd <= q_rd + 2'h1;
			end
			q_cnt <= q_cnt + {2'h0, q_push} - {2'h0, q_take};
			q_pend <= q_pend + {2'h0, launch & pick_fetch} -
				{2'h0, q_push};
		end
	end

	// Registered outputs
	wire in_cyc = (tst != T_IDLE) && (tst != T_HALT);
	wire ale_now = (next_tst == T_1) | halt_delay;
	// Strobes run T3 to T4, ending before the next T1, so they never overlap the next address
	wire strobe_win = (tst == T_2) | (tst == T_3) | (tst == T_W);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exec_done <= 1'b0;
			exec_rdata <= 16'h0;
			vector_ptr <= 10'h0;
			vector_valid <= 1'b0;
			queue_byte <= 8'h0;
			queue_valid <= 1'b0;
			muxed_addr_data_out <= 8'h0;
			muxed_addr_data_oe <= 1'b0;
			addr_hi_status <= 4'h0;
			upper_addr_lines <= 8'h0;
			min_ctl <= '0;
			max_ctl <= {3'h7, 1'b0};
		end else begin
			exec_done <= cap_exec_last;
			if (cap_exec_last & cap_read) begin
				exec_rdata <= exec_req.word ? {din_s1, rlow} :
					{8'h0, din_s1};
			end
			vector_valid <= cap_vec;
			if (cap_vec) begin
				vector_ptr <= {din_s1, 2'h0};
			end
			queue_valid <= (q_cnt != 3'h0) & ~q_take;
			queue_byte <= q_mem[q_take ? q_rd + 2'h1 : q_rd];
			// Address in T1, data or float after
			if (next_tst == T_1) begin
				muxed_addr_data_out <= next_addr[7:0];
				muxed_addr_data_oe <= ~pick_irq;
				upper_addr_lines <= next_addr[15:8];
				addr_hi_status <= next_addr[19:16];
			end else if (next_tst == T_2) begin
				muxed_addr_data_out <= cyc_wbyte;
				muxed_addr_data_oe <= ~is_read;
			end else if (next_tst == T_IDLE) begin
				muxed_addr_data_oe <= 1'b0;
			end
			min_ctl.addr_latch <= ~max_mode & ale_now & ~go_halt;
			min_ctl.io_select <= ~max_mode & ~cyc_code[2];
			min_ctl.xcvr_direction <= ~max_mode & ~is_read;
			min_ctl.xcvr_output_enable <= ~max_mode & in_cyc &
				(tst != T_1) & ~cyc_ack;
			min_ctl.min_cfg_status_copy <= ~max_mode & cyc_code[0];
			min_ctl.rd_strobe <= ~max_mode & strobe_win &
				is_read & ~cyc_ack & (cyc_code != `ST_HALT);
			min_ctl.wr_strobe <= ~max_mode & strobe_win & ~is_read;
			min_ctl.irq_ack_strobe <= ~max_mode & cyc_ack & strobe_win;
			// Status passive when not in max mode
			{max_ctl.cycle_status_hi, max_ctl.cycle_status_mid,
				max_ctl.cycle_status_lo} <= max_mode ?
				(launch ? next_code : cyc_end ? `ST_PASSIVE : cyc_code) :
				`ST_PASSIVE;
			max_ctl.bus_lock <= max_mode & cyc_ack &
				((~ack_second & tst == T_1) | (tst == T_2 & ~ack_second) |
				(tst == T_3) | (tst == T_W) | (tst == T_4 & ~ack_second) |
				(ack_second & tst == T_1));
		end
	end
	// each extra byte cycle is four clocks, T1 to T4
	// no upper byte select port is provided
endmodule // bus_interface_unit

// >>> bus_interface_unit_tb.sv
// Self-checking bench for the byte-wide bus interface unit.
// Assumes the checker binds itself and the partner answers the bus.
`timescale 1ns/100ps
`include "biu_defs.svh"
module bus_interface_unit_tb;
	logic clk = 1'b0, sys_rst = 1'b1, config_strap = 1'b1, irq_req = 1'b0;
	logic flush = 1'b1, queue_pop = 1'b0, exec_valid = 1'b0, slow = 1'b0;
	logic [19:0] fetch_addr = 20'h0;
	logic [7:0] vec_type = 8'h0;
	biu_pkg::exec_req_t exec_req = '0;
	logic ready, exec_done, vector_valid, ad_oe, exp_io = 1'b0, q_valid;
	logic [15:0] exec_rdata;
	logic [9:0] vector_ptr;
	logic [7:0] queue_byte, ad_in, ad_out, upper;
	biu_pkg::min_ctl_t min_ctl;
	biu_pkg::max_ctl_t max_ctl;
	logic [2:0] last_code = 3'h7;
	logic [2:0] codes [1:4] = '{`ST_DATA_READ, `ST_DATA_WRITE, `ST_IO_READ,
		`ST_IO_WRITE};
	integer errors = 0, n_compared = 0, seed = 32, n_rd = 0, n_wr = 0;
	integer n_ack = 0, len = 0, len1 = 0, k;
	logic [7:0] exp_wr[$];
	always #5 clk = ~clk;
	bus_interface_unit u_bus_interface_unit (.clk(clk), .sys_rst(sys_rst),
		.config_strap(config_strap), .ready(ready), .irq_req(irq_req),
		.flush(flush), .fetch_addr(fetch_addr), .exec_req(exec_req),
		.exec_valid(exec_valid), .exec_done(exec_done),
		.exec_rdata(exec_rdata), .vector_ptr(vector_ptr),
		.vector_valid(vector_valid), .queue_pop(queue_pop),
		.queue_byte(queue_byte), .queue_valid(q_valid),
		.muxed_addr_data_in(ad_in),
		.muxed_addr_data_out(ad_out), .muxed_addr_data_oe(ad_oe),
		.addr_hi_status(), .upper_addr_lines(upper), .min_ctl(min_ctl),
		.max_ctl(max_ctl));
	biu_bus_partner u_biu_bus_partner (.clk(clk), .slow(slow),
		.vec_type(vec_type), .muxed_addr_data_out(ad_out),
		.upper_addr_lines(upper), .min_ctl(min_ctl), .max_ctl(max_ctl),
		.muxed_addr_data_in(ad_in), .ready(ready));
	function automatic logic [7:0] mem(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		n_rd = n_rd + $rose(min_ctl.rd_strobe);
		n_ack = n_ack + $rose(min_ctl.irq_ack_strobe);
		if ($rose(min_ctl.rd_strobe) || $rose(min_ctl.wr_strobe))
			check("io select", 16'(min_ctl.io_select), 16'(exp_io));
		if ($rose(min_ctl.wr_strobe)) begin
			n_wr = n_wr + 1;
			check("write byte", {8'h0, ad_out}, {8'h0, exp_wr.pop_front()});
		end
		if (max_ctl[3:1] != `ST_PASSIVE && max_ctl[3:1] != `ST_CODE_READ)
			last_code <= max_ctl[3:1];
	end
	task automatic op(input biu_pkg::req_kind_t t, input logic w,
		input logic [15:0] d);
		logic [19:0] a;
		logic [15:0] e;
		a = 20'($random(seed));
		e = w ? {mem(a + 20'h1), mem(a)} : {8'h0, mem(a)};
		exec_req <= '{addr: a, wdata: d, word: w, kind: t};
		exec_valid <= 1'b1;
		exp_io <= t inside {biu_pkg::REQ_IO_RD, biu_pkg::REQ_IO_WR};
		last_code <= `ST_PASSIVE;
		if (config_strap && t inside {biu_pkg::REQ_MEM_WR, biu_pkg::REQ_IO_WR}) begin
			exp_wr.push_back(d[7:0]);
			if (w)
				exp_wr.push_back(d[15:8]);
		end
		len = 0;
		do begin
			@(posedge clk);
			len = len + 1;
		end while (exec_done !== 1'b1 && len < 200);
		exec_valid <= 1'b0;
		if (len == 200) begin
			errors = errors + 1;
			complete_run;
		end
		if (config_strap && t inside {biu_pkg::REQ_MEM_RD, biu_pkg::REQ_IO_RD})
			check("read data", w ? exec_rdata : {8'h0, exec_rdata[7:0]}, e);
		@(posedge clk);
	endtask
	task automatic irq;
		integer i;
		vec_type <= 8'($random(seed));
		irq_req <= 1'b1;
		n_ack = 0;
		for (i = 0; i < 200 && n_ack == 0 && last_code != 3'h0; i++)
			@(posedge clk);
		irq_req <= 1'b0;
		for (i = i; i < 400 && vector_valid !== 1'b1; i++)
			@(posedge clk);
		if (i >= 400) begin
			errors = errors + 1;
			complete_run;
		end
		check("vector", {6'h0, vector_ptr}, {6'h0, vec_type, 2'h0});
	endtask
	task automatic restart;
		sys_rst <= 1'b1;
		flush <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		fetch_addr <= 20'($random(seed));
		repeat (3) @(posedge clk);
		n_rd = 0;
		flush <= 1'b0;
		repeat (80) @(posedge clk);
	endtask
	initial begin
		restart;
		check("fill fetches", n_rd[15:0], 16'h4);
		n_rd = 0;
		repeat (5) begin
			check("queue byte", {8'h0, queue_byte}, {8'h0, mem(fetch_addr)});
			check("queue valid", {15'h0, q_valid}, 16'h1);
			queue_pop <= 1'b1;
			fetch_addr <= fetch_addr + 20'h1;
			@(posedge clk);
			queue_pop <= 1'b0;
			repeat (20) @(posedge clk);
		end
		check("refills", n_rd[15:0], 16'h5);
		op(biu_pkg::REQ_MEM_RD, 1'b0, 16'h0);
		len1 = len;
		op(biu_pkg::REQ_MEM_RD, 1'b1, 16'h0);
		check("word extra", 16'(len - len1), 16'h4);
		slow <= 1'b1;
		op(biu_pkg::REQ_MEM_WR, 1'b1, 16'($random(seed)));
		op(biu_pkg::REQ_IO_RD, 1'b0, 16'h0);
		op(biu_pkg::REQ_IO_WR, 1'b0, 16'($random(seed)));
		check("write cycles", n_wr[15:0], 16'h3);
		irq;
		repeat (10) @(posedge clk);
		check("ack cycles", n_ack[15:0], 16'h2);
		config_strap <= 1'b0;
		restart;
		for (k = 1; k < 5; k++) begin
			op(biu_pkg::req_kind_t'(k[2:0]), 1'b0, 16'h0);
			check("status", {13'h0, last_code}, {13'h0, codes[k]});
		end
		irq;
		check("ack status", {13'h0, last_code}, 16'(`ST_IRQ_ACK));
		complete_run;
	end
endmodule // bus_interface_unit_tb
